// file: pae_phy_autoneg_energy_detect_sleep_mode_regs.sv
// Purpose: Autoneg advertise, partner, expansion and sleep-timing registers
// Assumes: Management access pulses and link events are on clk
// Notes: Read data appears one cycle after the read strobe
module pae_phy_autoneg_energy_detect_sleep_mode_regs
   import pae_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] mgmt_phy_addr,
   input wire logic [4:0] mgmt_reg_index,
   input wire logic mgmt_wr_en,
   input wire logic mgmt_rd_en,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata,
   output logic mgmt_rdata_valid,
   input wire logic lcw_valid,
   input wire logic [15:0] lcw_word,
   input wire logic an_restart,
   input wire logic an_complete,
   input wire logic partner_an_able,
   input wire logic parallel_fault,
   input wire logic rx_nlp_pin,
   input wire logic energy_pin,
   input wire logic auto_mdix_en,
   input wire logic manual_mode,
   output logic [4:0] management_phy_address,
   output logic energy_detect_sleep_mode,
   output logic tx_nlp,
   output logic wake_pulse,
   output logic pause_sym,
   output logic pause_asym,
   output logic [12:0] xover_ext_ms
);
   pae_sleep_if sif ();

   logic [15:0] adv_q, adv_d, tmr_q, tmr_d, lpa_q, lpa_d;
   logic [15:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic ack_q, ack_d, lpnp_q, lpnp_d;
   logic pdf_q, pdf_d, pr_q, pr_d;
   logic sleep_en_q, sleep_en_d;
   logic [4:0] addr_q, addr_d;
   logic psym_q, psym_d, pasym_q, pasym_d;
   pae_ms_t xov_q, xov_d;
   logic nlp_lvl, nlp_old_q, energy_lvl;
   logic hit_wr, hit_rd, rd_exp;
   logic [15:0] lpa_view, exp_view;
   logic [1:0] lp, la;

   pae_sync3 u_sync_nlp (
      .clk(clk),
      .rst(rst),
      .pin(rx_nlp_pin),
      .level(nlp_lvl)
   );

   pae_sync3 u_sync_energy (
      .clk(clk),
      .rst(rst),
      .pin(energy_pin),
      .level(energy_lvl)
   );

   pae_sleep_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_sleep (
      .clk(clk),
      .rst(rst),
      .sif(sif)
   );

   assign sif.sleep_en = sleep_en_q;
   assign sif.tx_en = tmr_q[TMR_TXEN];
   assign sif.tx_sel = tmr_q[TMR_TXSEL_LO +: 2];
   assign sif.single_wake = tmr_q[TMR_SWAKE];
   assign sif.rx_sel = tmr_q[TMR_RXSEL_LO +: 2];
   assign sif.energy = energy_lvl;
   assign sif.rx_nlp = nlp_lvl & ~nlp_old_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nlp_old_q <= 1'b0;
      end else begin
         nlp_old_q <= nlp_lvl;
      end
   end

   // Management access only answers at this device's own address
   always_comb begin
      hit_wr = mgmt_wr_en && (mgmt_phy_addr == addr_q);
      hit_rd = mgmt_rd_en && (mgmt_phy_addr == addr_q);
      rd_exp = hit_rd && (mgmt_reg_index == IDX_EXP);
   end

   // Register views as software sees them
   always_comb begin
      lpa_view = lpa_q & LPA_CAPMASK;
      lpa_view[LPA_ACK] = ack_q;
      lpa_view[4:0] = SEL_8023;
      exp_view = '0;
      exp_view[EXP_PDF] = pdf_q;
      exp_view[EXP_LPNP] = lpnp_q;
      exp_view[EXP_PR] = pr_q;
      exp_view[EXP_LPAN] = partner_an_able;
   end

   // Writable register state
   always_comb begin
      adv_d = adv_q;
      tmr_d = tmr_q;
      sleep_en_d = sleep_en_q;
      addr_d = addr_q;
      if (hit_wr) begin
         unique case (mgmt_reg_index)
            IDX_ADV: adv_d = mgmt_wdata & ADV_WMASK;
            IDX_TMR: tmr_d = mgmt_wdata & TMR_WMASK;
            IDX_MODE: sleep_en_d = mgmt_wdata[MODE_SLEEP_EN];
            IDX_SPEC: addr_d = mgmt_wdata[4:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         adv_q <= ADV_RESET;
         tmr_q <= TMR_RESET;
         sleep_en_q <= 1'b0;
         addr_q <= ADDR_RESET;
      end else begin
         adv_q <= adv_d;
         tmr_q <= tmr_d;
         sleep_en_q <= sleep_en_d;
         addr_q <= addr_d;
      end
   end

   // Partner capture and latched expansion flags
   always_comb begin
      lpa_d = lpa_q;
      ack_d = ack_q;
      lpnp_d = lpnp_q;
      if (an_restart) begin
         lpa_d = '0;
         ack_d = 1'b0;
         lpnp_d = 1'b0;
      end
      if (lcw_valid) begin
         lpa_d = lcw_word & LPA_CAPMASK;
         ack_d = 1'b1;
         lpnp_d = lcw_word[LPA_NP];
      end
      pdf_d = lh_next(pdf_q, parallel_fault, rd_exp);
      pr_d = lh_next(pr_q, lcw_valid, rd_exp);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lpa_q <= '0;
         ack_q <= 1'b0;
         lpnp_q <= 1'b0;
         pdf_q <= 1'b0;
         pr_q <= 1'b0;
      end else begin
         lpa_q <= lpa_d;
         ack_q <= ack_d;
         lpnp_q <= lpnp_d;
         pdf_q <= pdf_d;
         pr_q <= pr_d;
      end
   end

   // Read port
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = hit_rd;
      if (hit_rd) begin
         unique case (mgmt_reg_index)
            IDX_ADV: rdata_d = adv_q;
            IDX_LPA: rdata_d = lpa_view;
            IDX_EXP: rdata_d = exp_view;
            IDX_TMR: rdata_d = tmr_q;
            IDX_MODE: rdata_d = 16'(sleep_en_q) << MODE_SLEEP_EN;
            IDX_SPEC: rdata_d = {11'h000, addr_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Pause resolution keeps symmetric ahead of asymmetric, never both
   always_comb begin
      la = adv_q[ADV_PAUSE_LO +: 2];
      lp = lpa_q[LPA_PAUSE_LO +: 2];
      psym_d = 1'b0;
      pasym_d = 1'b0;
      if (an_complete) begin
         psym_d = la[0] & lp[0];
         pasym_d = la[1] & lp[1] & ~(la[0] & lp[0]);
      end
   end

   // Crossover extension in milliseconds
   always_comb begin
      xov_d = '0;
      if (sif.sleeping && tmr_q[TMR_XEDPD]) begin
         xov_d = XOVER_ENERGY_DETECT_SLEEP_MODE_MS;
      end
      if (auto_mdix_en && manual_mode && tmr_q[TMR_XMAN]) begin
         xov_d = xov_d + XOVER_MAN_MS;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         psym_q <= 1'b0;
         pasym_q <= 1'b0;
         xov_q <= '0;
      end else begin
         psym_q <= psym_d;
         pasym_q <= pasym_d;
         xov_q <= xov_d;
      end
   end

   assign mgmt_rdata = rdata_q;
   assign mgmt_rdata_valid = rvalid_q;
   assign management_phy_address = addr_q;
   assign energy_detect_sleep_mode = sif.sleeping;
   assign tx_nlp = sif.tx_nlp;
   assign wake_pulse = sif.wake;
   assign pause_sym = psym_q;
   assign pause_asym = pasym_q;
   assign xover_ext_ms = xov_q;
endmodule : pae_phy_autoneg_energy_detect_sleep_mode_regs

// file: pae_pkg.sv
// Purpose: Constants and helpers for the autoneg and sleep-timing registers
// Assumes: 16-bit management registers reached by 5-bit register index
// Notes: Pulse and window times are in milliseconds and turned into cycles by one count
package pae_pkg;
   localparam logic [4:0] IDX_ADV = 5'h04;
   localparam logic [4:0] IDX_LPA = 5'h05;
   localparam logic [4:0] IDX_EXP = 5'h06;
   localparam logic [4:0] IDX_TMR = 5'h10;
   localparam logic [4:0] IDX_MODE = 5'h11;
   localparam logic [4:0] IDX_SPEC = 5'h12;

   localparam logic [15:0] ADV_RESET = 16'h01E1;
   localparam logic [15:0] ADV_WMASK = 16'h2DFF;
   localparam logic [15:0] LPA_CAPMASK = 16'h2FE0;
   localparam logic [15:0] TMR_RESET = 16'h0000;
   localparam logic [15:0] TMR_WMASK = 16'hFC03;
   localparam logic [4:0] SEL_8023 = 5'h01;
   localparam logic [4:0] ADDR_RESET = 5'h01;

   localparam int ADV_PAUSE_LO = 10;
   localparam int LPA_NP = 15;
   localparam int LPA_ACK = 14;
   localparam int LPA_PAUSE_LO = 10;
   localparam int EXP_PDF = 4;
   localparam int EXP_LPNP = 3;
   localparam int EXP_PR = 1;
   localparam int EXP_LPAN = 0;
   localparam int TMR_TXEN = 15;
   localparam int TMR_TXSEL_LO = 13;
   localparam int TMR_SWAKE = 12;
   localparam int TMR_RXSEL_LO = 10;
   localparam int TMR_XEDPD = 1;
   localparam int TMR_XMAN = 0;
   localparam int MODE_SLEEP_EN = 13;

   typedef logic [12:0] pae_ms_t;
   localparam pae_ms_t TX_MS_00 = 13'd1000;
   localparam pae_ms_t TX_MS_01 = 13'd768;
   localparam pae_ms_t TX_MS_10 = 13'd512;
   localparam pae_ms_t TX_MS_11 = 13'd256;
   localparam pae_ms_t RX_MS_00 = 13'd64;
   localparam pae_ms_t RX_MS_01 = 13'd256;
   localparam pae_ms_t RX_MS_10 = 13'd512;
   localparam pae_ms_t RX_MS_11 = 13'd1000;
   localparam pae_ms_t XOVER_ENERGY_DETECT_SLEEP_MODE_MS = 13'd2976;
   localparam pae_ms_t XOVER_MAN_MS = 13'd1984;

   localparam int MS_NS = 1000000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_AWAKE,
      ST_SLEEP,
      ST_WOKE
   } pae_state_e;

   // Latch-high update: a new event beats a clearing read
   function automatic logic lh_next(input logic q, input logic set,
                                    input logic clr);
      return set | (q & ~clr);
   endfunction : lh_next

   function automatic pae_ms_t tx_interval(input logic [1:0] sel);
      case (sel)
         2'b00: return TX_MS_00;
         2'b01: return TX_MS_01;
         2'b10: return TX_MS_10;
         default: return TX_MS_11;
      endcase
   endfunction : tx_interval

   function automatic pae_ms_t rx_window(input logic [1:0] sel);
      case (sel)
         2'b00: return RX_MS_00;
         2'b01: return RX_MS_01;
         2'b10: return RX_MS_10;
         default: return RX_MS_11;
      endcase
   endfunction : rx_window
endpackage : pae_pkg

// file: pae_sleep_if.sv
// Purpose: Carries sleep-timer settings and results between modules
// Assumes: Single clock domain
// Notes: Register side drives settings, timer side drives results
interface pae_sleep_if;
   logic sleep_en;
   logic tx_en;
   logic [1:0] tx_sel;
   logic single_wake;
   logic [1:0] rx_sel;
   logic energy;
   logic rx_nlp;
   logic sleeping;
   logic tx_nlp;
   logic wake;

   modport regs (output sleep_en, output tx_en, output tx_sel,
                 output single_wake, output rx_sel, output energy,
                 output rx_nlp, input sleeping, input tx_nlp, input wake);
   modport tmr (input sleep_en, input tx_en, input tx_sel,
                input single_wake, input rx_sel, input energy,
                input rx_nlp, output sleeping, output tx_nlp, output wake);
endinterface : pae_sleep_if

// file: pae_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes: Output follows only when stages two and three agree
module pae_sync3
   import pae_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

   always_comb begin
      lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level = lvl_q;
endmodule : pae_sync3

// file: pae_sleep_timer.sv
// Purpose: Energy-detect sleep state, link pulse send and wake detect
// Assumes: rx_nlp is a one-cycle pulse, energy a clean level
// Notes: Millisecond prescaler sets timing grain to one ms
module pae_sleep_timer
   import pae_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
)
(
   input wire logic clk,
   input wire logic rst,
   pae_sleep_if.tmr sif
);
   localparam int PW = $clog2(CYC_PER_MS + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

   pae_state_e st_q, st_d;
   logic [PW-1:0] pre_q, pre_d;
   pae_ms_t tx_ms_q, tx_ms_d, win_q, win_d;
   logic armed_q, armed_d, txp_q, txp_d, wake_q, wake_d;
   logic slp_q, slp_d;
   logic tick;

   always_comb begin
      tick = (pre_q == PRE_LAST);
      pre_d = tick ? '0 : pre_q + PW'(1);
      st_d = st_q;
      tx_ms_d = tx_ms_q;
      win_d = win_q;
      armed_d = armed_q;
      txp_d = 1'b0;
      wake_d = 1'b0;
      unique case (st_q)
         ST_AWAKE: begin
            tx_ms_d = '0;
            armed_d = 1'b0;
            if (sif.sleep_en && !sif.energy) begin
               st_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (sif.tx_en && tick) begin
               if (tx_ms_q + 13'd1 >= tx_interval(sif.tx_sel)) begin
                  tx_ms_d = '0;
                  txp_d = 1'b1;
               end else begin
                  tx_ms_d = tx_ms_q + 13'd1;
               end
            end
            if (armed_q && tick) begin
               if (win_q + 13'd1 >= rx_window(sif.rx_sel)) begin
                  armed_d = 1'b0;
               end else begin
                  win_d = win_q + 13'd1;
               end
            end
            if (sif.rx_nlp) begin
               if (sif.single_wake || armed_q) begin
                  wake_d = 1'b1;
                  st_d = ST_WOKE;
               end else begin
                  armed_d = 1'b1;
                  win_d = '0;
               end
            end
            if (!sif.sleep_en) begin
               st_d = ST_AWAKE;
            end
         end
         ST_WOKE: begin
            // Held awake until energy returns so the link can come up
            if (sif.energy || !sif.sleep_en) begin
               st_d = ST_AWAKE;
            end
         end
      endcase
      // Registered so the sleep indication leaves the block from a flop
      slp_d = (st_d == ST_SLEEP);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_AWAKE;
         pre_q <= '0;
         tx_ms_q <= '0;
         win_q <= '0;
         armed_q <= 1'b0;
         txp_q <= 1'b0;
         wake_q <= 1'b0;
         slp_q <= 1'b0;
      end else begin
         st_q <= st_d;
         pre_q <= pre_d;
         tx_ms_q <= tx_ms_d;
         win_q <= win_d;
         armed_q <= armed_d;
         txp_q <= txp_d;
         wake_q <= wake_d;
         slp_q <= slp_d;
      end
   end

   assign sif.sleeping = slp_q;
   assign sif.tx_nlp = txp_q;
   assign sif.wake = wake_q;
endmodule : pae_sleep_timer

// file: pae_regs_properties.sv
// Purpose: Port-level checks for the autoneg and sleep-timing registers
// Assumes: One clock, asynchronous active-high reset
// Notes: Sees only top-level ports; attached by the bind at the foot
module pae_regs_properties
   import pae_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] mgmt_phy_addr,
   input wire logic [4:0] mgmt_reg_index,
   input wire logic mgmt_rd_en,
   input wire logic [15:0] mgmt_rdata,
   input wire logic mgmt_rdata_valid,
   input wire logic an_complete,
   input wire logic auto_mdix_en,
   input wire logic [4:0] management_phy_address,
   input wire logic energy_detect_sleep_mode,
   input wire logic tx_nlp,
   input wire logic pause_sym,
   input wire logic pause_asym,
   input wire logic [12:0] xover_ext_ms
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_pause_one;
      !(pause_sym && pause_asym);
   endproperty
   a_pause_one: assert property (p_pause_one)
      else $error("both pause outputs high");
   property p_pause_gate;
      !$past(an_complete) |-> !pause_sym && !pause_asym;
   endproperty
   a_pause_gate: assert property (p_pause_gate)
      else $error("pause resolved before autoneg done");
   property p_rd_ans;
      mgmt_rd_en && mgmt_phy_addr == management_phy_address
         |=> mgmt_rdata_valid;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("addressed read got no answer");
   property p_bad_addr;
      mgmt_rd_en && mgmt_phy_addr != management_phy_address
         |=> !mgmt_rdata_valid;
   endproperty
   a_bad_addr: assert property (p_bad_addr)
      else $error("read answered at foreign address");
   property p_exp_np;
      mgmt_rdata_valid && $past(mgmt_reg_index) == IDX_EXP
         |-> mgmt_rdata[15:5] == 11'h000 && !mgmt_rdata[2];
   endproperty
   a_exp_np: assert property (p_exp_np)
      else $error("expansion reserved or next-page bit set");
   property p_lpa_sel;
      mgmt_rdata_valid && $past(mgmt_reg_index) == IDX_LPA
         |-> mgmt_rdata[4:0] == SEL_8023 && !mgmt_rdata[12];
   endproperty
   a_lpa_sel: assert property (p_lpa_sel)
      else $error("partner selector wrong");
   property p_tmr_rsv;
      mgmt_rdata_valid && $past(mgmt_reg_index) == IDX_TMR
         |-> mgmt_rdata[9:2] == 8'h00;
   endproperty
   a_tmr_rsv: assert property (p_tmr_rsv)
      else $error("timer reserved bits nonzero");
   property p_tx_gate;
      tx_nlp |-> energy_detect_sleep_mode || $past(energy_detect_sleep_mode);
   endproperty
   a_tx_gate: assert property (p_tx_gate)
      else $error("link pulse sent while awake");
   property p_xover_energy_detect_sleep_mode;
      xover_ext_ms == XOVER_ENERGY_DETECT_SLEEP_MODE_MS
         || xover_ext_ms == XOVER_ENERGY_DETECT_SLEEP_MODE_MS + XOVER_MAN_MS
         |-> energy_detect_sleep_mode || $past(energy_detect_sleep_mode);
   endproperty
   a_xover_energy_detect_sleep_mode: assert property (p_xover_energy_detect_sleep_mode)
      else $error("sleep crossover extension while awake");
   property p_xover_man;
      !$past(auto_mdix_en) |-> xover_ext_ms == 13'h0000
         || xover_ext_ms == XOVER_ENERGY_DETECT_SLEEP_MODE_MS;
   endproperty
   a_xover_man: assert property (p_xover_man)
      else $error("manual crossover extension without auto crossover");
endmodule : pae_regs_properties

bind pae_phy_autoneg_energy_detect_sleep_mode_regs pae_regs_properties u_props (
   .clk(clk), .rst(rst), .mgmt_phy_addr(mgmt_phy_addr),
   .mgmt_reg_index(mgmt_reg_index), .mgmt_rd_en(mgmt_rd_en),
   .mgmt_rdata(mgmt_rdata), .mgmt_rdata_valid(mgmt_rdata_valid),
   .an_complete(an_complete), .auto_mdix_en(auto_mdix_en),
   .management_phy_address(management_phy_address),
   .energy_detect_sleep_mode(energy_detect_sleep_mode),
   .tx_nlp(tx_nlp), .pause_sym(pause_sym), .pause_asym(pause_asym),
   .xover_ext_ms(xover_ext_ms)
);

// file: pae_link_partner.sv
// Purpose: Link partner model: code words, link pulses and line energy
// Assumes: Changes land 1 ns after a rising clock edge
// Notes: Idle code word lines show the inverse of the last word sent
module pae_link_partner (
   input wire logic clk,
   output logic lcw_valid,
   output logic [15:0] lcw_word,
   output logic rx_nlp_pin,
   output logic energy_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      lcw_valid = 1'b0;
      lcw_word = 16'hffff;
      rx_nlp_pin = 1'b0;
      energy_pin = 1'b1;
   end
   task automatic send_word(input logic [15:0] w);
      @(posedge clk);
      #1 lcw_valid = 1'b1;
      lcw_word = w;
      @(posedge clk);
      #1 lcw_valid = 1'b0;
      lcw_word = ~w;
   endtask : send_word
   // Long enough to pass the receiver's agreement filter
   task automatic nlp();
      @(posedge clk);
      #1 rx_nlp_pin = 1'b1;
      repeat (8) @(posedge clk);
      #1 rx_nlp_pin = 1'b0;
      repeat (8) @(posedge clk);
   endtask : nlp
endmodule : pae_link_partner

// file: testbench.sv
// Purpose: Register and sleep-timing regression for the autoneg block
// Assumes: 4 cycles per ms so second-long timers stay short
// Notes: Only the 256 ms pulse interval is timed, to keep the run short
module testbench
   import pae_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CPM = 4;
   logic clk, rst, wr, rd, rv, lv, an_rs, an_c, p_able, pfault;
   logic nlp_p, en_p, mdix, man, sleep, txp, wake, psym, pasym;
   logic [4:0] pa, idx, paddr;
   logic [15:0] wd, rdata, lw;
   logic [12:0] xo;
   int err_count, cmp_count, n;

   pae_phy_autoneg_energy_detect_sleep_mode_regs #(.CYC_PER_MS(CPM)) u_dut (
      .clk(clk), .rst(rst), .mgmt_phy_addr(pa), .mgmt_reg_index(idx),
      .mgmt_wr_en(wr), .mgmt_rd_en(rd), .mgmt_wdata(wd),
      .mgmt_rdata(rdata), .mgmt_rdata_valid(rv), .lcw_valid(lv),
      .lcw_word(lw), .an_restart(an_rs), .an_complete(an_c),
      .partner_an_able(p_able), .parallel_fault(pfault),
      .rx_nlp_pin(nlp_p), .energy_pin(en_p), .auto_mdix_en(mdix),
      .manual_mode(man), .management_phy_address(paddr),
      .energy_detect_sleep_mode(sleep), .tx_nlp(txp), .wake_pulse(wake),
      .pause_sym(psym), .pause_asym(pasym), .xover_ext_ms(xo));
   pae_link_partner u_lp (.clk(clk), .lcw_valid(lv), .lcw_word(lw),
      .rx_nlp_pin(nlp_p), .energy_pin(en_p));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report

   initial begin
      #200000;
      err_count++;
      final_report();
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic wrc(input logic [4:0] i, input logic [15:0] d);
      tick(1);
      idx = i;
      wd = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
   endtask : wrc
   // Valid is checked always, data only where an answer is due
   task automatic rdc(input logic [4:0] i, input logic [15:0] e,
                      input logic v);
      tick(1);
      idx = i;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      chk({15'h0000, rv}, {15'h0000, v});
      if (v) chk(rdata, e);
   endtask : rdc
   function automatic logic ev(input int w);
      case (w)
         0: return sleep;
         1: return txp;
         default: return wake;
      endcase
   endfunction : ev
   task automatic wait_for(input int w, input int lim, output int k);
      k = 0;
      do begin
         tick(1);
         k++;
      end while (ev(w) !== 1'b1 && k < lim);
   endtask : wait_for
   task automatic count_ev(input int w, input int len, output int c);
      c = 0;
      repeat (len) begin
         tick(1);
         if (ev(w) === 1'b1) c++;
      end
   endtask : count_ev
   task automatic pulse_fault();
      tick(1);
      pfault = 1'b1;
      tick(1);
      pfault = 1'b0;
   endtask : pulse_fault

   initial begin
      rst = 1'b1;
      {wr, rd, an_rs, an_c, p_able, pfault, mdix, man} = 8'h00;
      pa = 5'h01;
      idx = 5'h00;
      wd = 16'h0000;
      err_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      chk({11'h000, paddr}, 16'h0001);
      rdc(IDX_ADV, 16'h01e1, 1'b1);
      rdc(IDX_LPA, 16'h0001, 1'b1);
      rdc(IDX_EXP, 16'h0000, 1'b1);
      rdc(IDX_TMR, 16'h0000, 1'b1);
      wrc(IDX_ADV, 16'hffff);
      rdc(IDX_ADV, 16'h2dff, 1'b1);
      wrc(IDX_TMR, 16'hffff);
      rdc(IDX_TMR, 16'hfc03, 1'b1);
      rdc(5'h07, 16'h0000, 1'b1);
      pa = 5'h02;
      wrc(IDX_ADV, 16'h0000);
      rdc(IDX_ADV, 16'h0000, 1'b0);
      pa = 5'h01;
      rdc(IDX_ADV, 16'h2dff, 1'b1);
      p_able = 1'b1;
      u_lp.send_word(16'hafe1);
      rdc(IDX_LPA, 16'h6fe1, 1'b1);
      rdc(IDX_EXP, 16'h000b, 1'b1);
      rdc(IDX_EXP, 16'h0009, 1'b1);
      pulse_fault();
      rdc(IDX_EXP, 16'h0019, 1'b1);
      rdc(IDX_EXP, 16'h0009, 1'b1);
      an_c = 1'b1;
      tick(3);
      chk({14'h0000, psym, pasym}, 16'h0002);
      an_c = 1'b0;
      an_rs = 1'b1;
      tick(1);
      an_rs = 1'b0;
      rdc(IDX_LPA, 16'h0001, 1'b1);
      wrc(5'h12, 16'h0003);
      pa = 5'h03;
      rdc(5'h12, 16'h0003, 1'b1);
      // Sleep with 256 ms pulse interval, sleep crossover, two-pulse wake
      mdix = 1'b1;
      man = 1'b1;
      wrc(IDX_TMR, 16'he003);
      u_lp.energy_pin = 1'b0;
      count_ev(0, 20, n);
      chk(n[15:0], 16'h0000);
      wrc(IDX_MODE, 16'h2000);
      wait_for(0, 60, n);
      chk({15'h0000, n < 60}, 16'h0001);
      tick(2);
      chk({3'h0, xo}, {3'h0, XOVER_ENERGY_DETECT_SLEEP_MODE_MS + XOVER_MAN_MS});
      wait_for(1, 1100, n);
      wait_for(1, 1100, n);
      chk({15'h0000, n >= CPM * 256 - 4 && n <= CPM * 256 + 4},
          16'h0001);
      fork
         u_lp.nlp();
         count_ev(2, 300, n);
      join
      chk(n[15:0], 16'h0000);
      u_lp.nlp();
      tick(40);
      // Wake pulse stands one cycle, inside the pin pulse, so watch alongside
      fork
         u_lp.nlp();
         wait_for(2, 40, n);
      join
      chk({15'h0000, n < 40}, 16'h0001);
      // Re-sleep with single-pulse wake and no pulses sent
      wrc(IDX_TMR, 16'h1001);
      u_lp.energy_pin = 1'b1;
      tick(20);
      u_lp.energy_pin = 1'b0;
      wait_for(0, 60, n);
      chk({15'h0000, n < 60}, 16'h0001);
      chk({3'h0, xo}, {3'h0, XOVER_MAN_MS});
      count_ev(1, 1100, n);
      chk(n[15:0], 16'h0000);
      fork
         u_lp.nlp();
         wait_for(2, 40, n);
      join
      chk({15'h0000, n < 40}, 16'h0001);
      final_report();
   end
endmodule : testbench
